/* File: common/icd_pkg.sv */
// Overview of operation
// - call pushes next address, loads 11-bit target
// - call fills pc bits 12:11 from latch
// - call takes two cycles, flags untouched
// - watchdog kick zeroes counter and prescaler
// - watchdog kick sets expiry and powerdown flags
// - register clear writes zero, sets null flag
// - accumulator clear writes zero, sets null flag
// - invert routes complement by destination bit
// - decrement routes result by destination bit
// - decrement-skip routes result by destination bit
// - zero result skips next, two cycles
package icd_pkg;
  localparam int PC_W        = 13;
  localparam int TARGET_W    = 11;
  localparam int ADDR_W      = 7;
  localparam int DATA_W      = 8;
  localparam int LATCH_LO    = 3;
  localparam int LATCH_HI    = 4;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [PC_W-1:0]   PC_RST   = 13'h0000;

  typedef enum logic [2:0] {
    OP_CALL   = 3'h0,
    OP_KICK   = 3'h1,
    OP_CLRREG = 3'h2,
    OP_CLRACC = 3'h3,
    OP_INV    = 3'h4,
    OP_DEC    = 3'h5,
    OP_DECSK  = 3'h6,
    OP_NONE   = 3'h7
  } icd_op_type;

  typedef enum logic [1:0] {
    ST_RUN  = 2'b01,
    ST_WAIT = 2'b10
  } icd_state_type;
endpackage

/* File: logic/icd_exec.sv */
`timescale 1ns/1ns
module icd_exec (
  // clock and reset
  input  wire logic                          mclk,
  input  wire logic                          rst,
  // instruction issue
  input  wire logic                          issue,
  input  wire logic [2:0]                    opcode,
  input  wire logic [icd_pkg::TARGET_W-1:0]  target,
  input  wire logic [icd_pkg::ADDR_W-1:0]    reg_addr,
  input  wire logic                          dest_sel,
  // operands
  input  wire logic [icd_pkg::DATA_W-1:0]    reg_rdata,
  input  wire logic [icd_pkg::DATA_W-1:0]    upper_pc_latch,
  input  wire logic [icd_pkg::PC_W-1:0]      pc_now,
  // register file write
  output logic                               reg_we,
  output logic [icd_pkg::ADDR_W-1:0]         reg_waddr,
  output logic [icd_pkg::DATA_W-1:0]         reg_wdata,
  // accumulator
  output logic [icd_pkg::DATA_W-1:0]         accumulator,
  // program counter and stack
  output logic                               pc_load,
  output logic [icd_pkg::PC_W-1:0]           pc_next,
  output logic                               stack_push,
  output logic [icd_pkg::PC_W-1:0]           stack_top,
  // watchdog
  output logic                               watchdog_clear,
  // status flags
  output logic                               result_null_flag,
  output logic                               watchdog_expiry_flag,
  output logic                               powerdown_flag,
  // sequencing
  output logic                               busy,
  output logic                               flush_next
);

  ////////////////////////////////////////////////////////////////
  // decode
  icd_pkg::icd_op_type op;
  icd_pkg::icd_state_type state_q;
  icd_pkg::icd_state_type state_d;
  logic                             go;
  logic [icd_pkg::DATA_W-1:0]       inv_val;
  logic [icd_pkg::DATA_W-1:0]       dec_val;
  logic                             dec_nil;
  logic                             is_alu;
  logic [icd_pkg::DATA_W-1:0]       alu_val;

  assign op      = icd_pkg::icd_op_type'(opcode);
  assign go      = issue && (state_q == icd_pkg::ST_RUN);
  assign inv_val = ~reg_rdata;
  assign dec_val = reg_rdata - 8'h01;
  assign dec_nil = (dec_val == icd_pkg::DATA_RST);
  assign is_alu  = (op == icd_pkg::OP_INV) || (op == icd_pkg::OP_DEC)
                   || (op == icd_pkg::OP_DECSK);
  assign alu_val = (op == icd_pkg::OP_INV) ? inv_val : dec_val;

  ////////////////////////////////////////////////////////////////
  // sequencing: two-cycle ops hold busy for one extra cycle
  always_comb begin
    state_d = state_q;
    case (state_q)
      icd_pkg::ST_RUN: begin
        if (go && (op == icd_pkg::OP_CALL)) begin
          state_d = icd_pkg::ST_WAIT;
        end else if (go && (op == icd_pkg::OP_DECSK) && dec_nil) begin
          state_d = icd_pkg::ST_WAIT;
        end
      end
      icd_pkg::ST_WAIT: begin
        state_d = icd_pkg::ST_RUN;
      end
      default: begin
        state_d = icd_pkg::ST_RUN;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // datapath registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q              <= icd_pkg::ST_RUN;
      reg_we               <= 1'b0;
      reg_waddr            <= '0;
      reg_wdata            <= icd_pkg::DATA_RST;
      accumulator          <= icd_pkg::DATA_RST;
      pc_load              <= 1'b0;
      pc_next              <= icd_pkg::PC_RST;
      stack_push           <= 1'b0;
      stack_top            <= icd_pkg::PC_RST;
      watchdog_clear       <= 1'b0;
      result_null_flag     <= 1'b0;
      watchdog_expiry_flag <= 1'b1;
      powerdown_flag       <= 1'b1;
      busy                 <= 1'b0;
      flush_next           <= 1'b0;
    end else begin
      state_q        <= state_d;
      busy           <= (state_d == icd_pkg::ST_WAIT);
      reg_we         <= 1'b0;
      pc_load        <= 1'b0;
      stack_push     <= 1'b0;
      watchdog_clear <= 1'b0;
      flush_next     <= 1'b0;
      if (go) begin
        case (op)
          icd_pkg::OP_CALL: begin
            stack_push <= 1'b1;
            stack_top  <= pc_now + 13'h0001;
            pc_load    <= 1'b1;
            pc_next    <= {upper_pc_latch[icd_pkg::LATCH_HI:icd_pkg::LATCH_LO],
                           target};
          end
          icd_pkg::OP_KICK: begin
            watchdog_clear       <= 1'b1;
            watchdog_expiry_flag <= 1'b1;
            powerdown_flag       <= 1'b1;
          end
          icd_pkg::OP_CLRREG: begin
            reg_we           <= 1'b1;
            reg_waddr        <= reg_addr;
            reg_wdata        <= icd_pkg::DATA_RST;
            result_null_flag <= 1'b1;
          end
          icd_pkg::OP_CLRACC: begin
            accumulator      <= icd_pkg::DATA_RST;
            result_null_flag <= 1'b1;
          end
          default: begin
            if (is_alu) begin
              if (dest_sel) begin
                reg_we    <= 1'b1;
                reg_waddr <= reg_addr;
                reg_wdata <= alu_val;
              end else begin
                accumulator <= alu_val;
              end
              if (op != icd_pkg::OP_DECSK) begin
                result_null_flag <= (alu_val == icd_pkg::DATA_RST);
              end
              if ((op == icd_pkg::OP_DECSK) && dec_nil) begin
                flush_next <= 1'b1;
              end
            end
          end
        endcase
      end
    end
  end

endmodule

/* File: test/icd_exec_sva.sv */
`timescale 1ns/1ns
module icd_exec_sva (
  input wire logic        mclk, rst, issue, busy, flush_next, reg_we, pc_load,
  input wire logic        watchdog_clear, result_null_flag,
  input wire logic        watchdog_expiry_flag, powerdown_flag,
  input wire logic [2:0]  opcode,
  input wire logic [7:0]  upper_pc_latch, reg_wdata, accumulator,
  input wire logic [10:0] target,
  input wire logic [12:0] pc_now, pc_next, stack_top
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire        take = issue && !busy, call = take && opcode == 3'h0, skp = take && opcode == 3'h6;
  wire [12:0] tgt = {upper_pc_latch[4:3], target};
  AST_CALL_PC: assert property (
    call |=> pc_load && pc_next == $past(tgt)) else $error("call target");
  AST_CALL_RET: assert property (
    call |=> stack_top == $past(pc_now) + 13'h0001) else $error("return address");
  AST_CALL_TWO: assert property (
    call |=> busy ##1 !busy) else $error("call length");
  AST_KICK: assert property (
    take && opcode == 3'h1 |=> watchdog_clear) else $error("kick");
  AST_CLR_REG: assert property (
    take && opcode == 3'h2 |=> reg_we && ~|reg_wdata && result_null_flag) else $error("clr");
  AST_CLR_ACC: assert property (
    take && opcode == 3'h3 |=> ~|accumulator && result_null_flag) else $error("clr acc");
  AST_SKIP_Z: assert property (
    skp |=> $stable(result_null_flag)) else $error("skip flag");
  AST_FLUSH: assert property (
    flush_next |-> busy && $past(skp)) else $error("flush");
  AST_KICK_FLAGS: assert property (
    take && opcode == 3'h1 |=> watchdog_expiry_flag && powerdown_flag) else $error("kick flags");
  AST_ONE_CYCLE: assert property (
    take && opcode inside {3'h2, 3'h3, 3'h4, 3'h5} |=> !busy) else $error("one cycle");
endmodule
bind icd_exec icd_exec_sva u_icd_exec_sva (.*);

/* File: test/tb.sv */
`timescale 1ns/1ns
module tb;
  logic        mclk = 1'b0, rst = 1'b1, issue = 1'b0, dest_sel = 1'b0, t, reg_we, pc_load;
  logic        stack_push, watchdog_clear, result_null_flag, watchdog_expiry_flag;
  logic        powerdown_flag, busy, flush_next;
  logic [2:0]  opcode = 3'h7;
  logic [6:0]  reg_addr = 7'h00, reg_waddr;
  logic [7:0]  reg_rdata = 8'h00, upper_pc_latch = 8'h00, reg_wdata, accumulator, v;
  logic [10:0] target = 11'h000;
  logic [12:0] pc_now = 13'h0000, pc_next, stack_top;
  logic [31:0] e = 32'h0000_0003, q[$];
  logic [25:0] p = 26'h0000000, qp[$];
  int          n_mismatch = 0, n_tests = 0;
  icd_exec u_icd_exec (.*);
  always #4 mclk = ~mclk;
  task automatic report_and_stop;
    if (n_mismatch == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) $display("[ERR] outputs exp %h got %h", exp, got);
    if (got !== exp) n_mismatch++;
  endtask
  task automatic chk_pc(input logic [25:0] exp, input logic [25:0] got);
    n_tests++;
    if (got !== exp) $display("[ERR] pc_next_stack_top exp %h got %h", exp, got);
    if (got !== exp) n_mismatch++;
  endtask
  always @(posedge mclk) #2 if (qp.size() > 0) chk_pc(qp.pop_front(),
    {pc_next, stack_top});
  always @(posedge mclk) #2 if (q.size() > 0) chk(q.pop_front(),
    {reg_we, reg_waddr, reg_wdata, accumulator, result_null_flag, flush_next, busy,
     pc_load, stack_push, watchdog_clear, watchdog_expiry_flag, powerdown_flag});
  initial begin
    void'($urandom(96702));
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    q.push_back(e);
    qp.push_back(p);
    repeat (500) begin
      @(negedge mclk);
      issue = $urandom_range(7) != 0;
      {opcode, reg_addr, dest_sel, target, upper_pc_latch} = 30'($urandom);
      pc_now = 13'($urandom);
      reg_rdata = $urandom_range(3) == 0 ? 8'h01 : 8'($urandom);
      v = opcode == 3'h4 ? ~reg_rdata : reg_rdata - 8'h01;
      t = issue && !e[5];
      e &= 32'h7fff_ff83;
      if (t) case (opcode)
        3'h0: begin
          e[5:3] = 3'h7;
          p = {upper_pc_latch[4:3], target, pc_now + 13'h0001};
        end
        3'h1: e[2] = 1'b1;
        3'h2: e[31:7] = {1'b1, reg_addr, 8'h00, e[15:8], 1'b1};
        3'h3: e[15:7] = 9'h001;
        3'h4, 3'h5, 3'h6: begin
          if (dest_sel) e[31:16] = {1'b1, reg_addr, v};
          else e[15:8] = v;
          if (opcode == 3'h6) e[6:5] = {2{v == 8'h00}};
          else e[7] = v == 8'h00;
        end
        default: ;
      endcase
      q.push_back(e);
      qp.push_back(p);
    end
    #20;
    report_and_stop;
  end
  initial begin
    #8000;
    n_mismatch++;
    report_and_stop;
  end
endmodule
